//--- hdl/pscs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "pscs_cfg.svh"
// Contract
// - Identifiers outside 00..99 are not accepted on define or enter.
// - Return carries no identifier; it ends the running body and pops.
// - Main scan runs to the first define marker, then wraps to 00000.
// - Bodies never run by fall-through, only by enter or interrupt.
// - Program end follows the last return and terminates the program.
// - Define marker in main region stops the scan at that point.
// - One-shot inside a body holds until that body runs again.
// - Define and return leave all condition flags unchanged.
// - Enter with condition ON runs body then resumes after call.
// - One identifier may be entered from any number of call sites.
// - Enter nests up to sixteen; each return pops to its caller.
// - Enter naming the running subroutine is a self-call error.
// - Enter naming an undefined identifier sets the error flag.
// - Enter beyond sixteen nesting levels sets the error flag.
// - With the error flag ON, enter makes no call and no push.
// - Ids 00..31 start by input interrupt, 99 by scheduled one.
// - Interrupt body suspends main and resumes at suspension point.
module pscs_sequencer
  import pscs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire pscs_def_t defLoad,
  input wire logic defClear,
  input wire pscs_instr_t instr,
  input wire pscs_irq_t irq,
  input wire logic errorClear,
  output logic jumpValid,
  output pscs_addr_t jumpAddr,
  output logic errorFlag,
  output logic scanWrap,
  output logic programEnd,
  output logic [`PSCS_DEPTH_W-1:0] depth,
  output pscs_id_t activeId,
  output logic inSubroutine,
  output logic [`PSCS_ONESHOT_W-1:0] oneShotOut
);

  // ==========================================================
  // Definition table
  // One valid bit and start address per identifier
  logic [`PSCS_NUM_IDS-1:0] defValid_q;
  pscs_addr_t defAddr_q [`PSCS_NUM_IDS];

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      defValid_q <= '0;
    end else if (defClear) begin
      defValid_q <= '0;
    end else if (defLoad.valid && defLoad.id <= `PSCS_ID_MAX) begin
      defValid_q[defLoad.id] <= 1'b1;
    end
  end

  // Address array kept without reset; valid bits guard every read
  always_ff @(posedge clock) begin
    if (defLoad.valid && defLoad.id <= `PSCS_ID_MAX) begin
      defAddr_q[defLoad.id] <= defLoad.addr;
    end
  end

  // ==========================================================
  // Return stack
  pscs_addr_t retStack_q [`PSCS_DEPTH];
  pscs_id_t idStack_q [`PSCS_DEPTH];
  logic [`PSCS_DEPTH_W-1:0] sp_q;
  pscs_id_t curId_q;

  // ==========================================================
  // Instruction decode
  logic isDefine;
  logic isReturn;
  logic isEnter;
  logic isEnd;
  logic idOk;
  logic selfCall;
  logic missing;
  logic overNest;
  logic enterFault;
  logic doCall;
  logic doIrq;
  logic irqIdOk;
  logic doPop;
  logic doWrap;

  always_comb begin
    isDefine = instr.valid && instr.op == PSCS_OP_DEFINE;
    isReturn = instr.valid && instr.op == PSCS_OP_RETURN;
    isEnter = instr.valid && instr.op == PSCS_OP_ENTER && instr.cond;
    isEnd = instr.valid && instr.op == PSCS_OP_END;
    idOk = instr.id <= `PSCS_ID_MAX;
    selfCall = sp_q != '0 && curId_q == instr.id;
    missing = !idOk || !defValid_q[instr.id[6:0] % 7'd100];
    overNest = sp_q == 5'(`PSCS_DEPTH);
    enterFault = isEnter && (selfCall || missing || overNest);
    // Enter is blocked while the flag stands, no push at all
    doCall = isEnter && !errorFlag && !enterFault;
    // Interrupt sources: inputs 00..31 and scheduled 99
    irqIdOk = irq.id <= `PSCS_IRQ_ID_MAX || irq.id == `PSCS_SCHED_ID;
    doIrq = irq.valid && irqIdOk && defValid_q[irq.id[6:0] % 7'd100]
      && !overNest && !doCall;
    doPop = isReturn && sp_q != '0 && !doIrq;
    // Define seen with empty stack is the main region ending
    doWrap = isDefine && sp_q == '0 && !doIrq;
  end

  // ==========================================================
  // Stack pointer and frames
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sp_q <= '0;
      curId_q <= '0;
    end else if (doCall || doIrq) begin
      sp_q <= sp_q + 5'd1;
      curId_q <= doCall ? instr.id : irq.id;
    end else if (doPop) begin
      sp_q <= sp_q - 5'd1;
      curId_q <= idStack_q[4'(sp_q - 5'd1)];
    end else if (doWrap) begin
      sp_q <= '0;
    end
  end

  // Caller id kept so the self-call check follows nesting
  always_ff @(posedge clock) begin
    if (doCall) begin
      retStack_q[4'(sp_q)] <= pscs_addr_t'(instr.addr + 17'd1);
      idStack_q[4'(sp_q)] <= curId_q;
    end else if (doIrq) begin
      retStack_q[4'(sp_q)] <= irq.retAddr;
      idStack_q[4'(sp_q)] <= curId_q;
    end
  end

  // ==========================================================
  // Error flag
  // Set wins over clear only while the flag is low; define and return never touch it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      errorFlag <= 1'b0;
    end else if (enterFault && !errorFlag) begin
      errorFlag <= 1'b1;
    end else if (errorClear) begin
      errorFlag <= 1'b0;
    end
  end

  // ==========================================================
  // Jump outputs
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      jumpValid <= 1'b0;
      jumpAddr <= '0;
      scanWrap <= 1'b0;
      programEnd <= 1'b0;
    end else begin
      jumpValid <= doCall || doIrq || doPop || doWrap || isEnd;
      scanWrap <= doWrap || (isEnd && sp_q == '0);
      programEnd <= isEnd;
      if (doIrq) begin
        jumpAddr <= defAddr_q[irq.id[6:0] % 7'd100];
      end else if (doCall) begin
        jumpAddr <= defAddr_q[instr.id[6:0] % 7'd100];
      end else if (doPop) begin
        jumpAddr <= retStack_q[4'(sp_q - 5'd1)];
      end else if (doWrap || isEnd) begin
        jumpAddr <= `PSCS_SCAN_START;
      end
    end
  end

  // ==========================================================
  // Status mirrors
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      depth <= '0;
      activeId <= '0;
      inSubroutine <= 1'b0;
    end else begin
      depth <= sp_q;
      activeId <= curId_q;
      inSubroutine <= sp_q != '0;
    end
  end

  // ==========================================================
  // One-shot outputs
  // Only refreshed when the owning body executes, so a pulse
  // raised in a body stays on until that body runs again
  logic [`PSCS_ONESHOT_W-1:0] prevCond_q;
  logic isOneShot;
  logic [2:0] osIdx;

  always_comb begin
    isOneShot = instr.valid && instr.op == PSCS_OP_ONESHOT;
    osIdx = instr.id[2:0];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      oneShotOut <= '0;
      prevCond_q <= '0;
    end else if (isOneShot) begin
      oneShotOut[osIdx] <= instr.cond && !prevCond_q[osIdx];
      prevCond_q[osIdx] <= instr.cond;
    end
  end

endmodule : pscs_sequencer
`default_nettype wire

//--- shared/pscs_cfg.svh
`ifndef PSCS_CFG_SVH
`define PSCS_CFG_SVH
// ==========================================================
// Widths and limits
`define PSCS_ADDR_W 17
`define PSCS_ID_W 7
`define PSCS_NUM_IDS 100
`define PSCS_ID_MAX 7'h63
`define PSCS_IRQ_ID_MAX 7'h1F
`define PSCS_SCHED_ID 7'h63
`define PSCS_DEPTH 16
`define PSCS_DEPTH_W 5
`define PSCS_SCAN_START 17'h00000
`define PSCS_ONESHOT_W 8
`endif

//--- shared/pscs_pkg.sv
`include "pscs_cfg.svh"
package pscs_pkg;
  typedef logic [`PSCS_ADDR_W-1:0] pscs_addr_t;
  typedef logic [`PSCS_ID_W-1:0] pscs_id_t;
  typedef enum logic [2:0] {
    PSCS_OP_NONE,
    PSCS_OP_DEFINE,
    PSCS_OP_RETURN,
    PSCS_OP_ENTER,
    PSCS_OP_END,
    PSCS_OP_ONESHOT
  } pscs_op_t;
  // One decoded instruction as fetched by the execution engine
  typedef struct packed {
    logic valid;
    pscs_op_t op;
    pscs_id_t id;
    logic cond;
    pscs_addr_t addr;
  } pscs_instr_t;
  // Definition table load entry
  typedef struct packed {
    logic valid;
    pscs_id_t id;
    pscs_addr_t addr;
  } pscs_def_t;
  typedef struct packed {
    logic valid;
    pscs_id_t id;
    pscs_addr_t retAddr;
  } pscs_irq_t;
endpackage : pscs_pkg

//--- verification/pscs_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "pscs_cfg.svh"
// ============================================================
// Sequencer port checks
module pscs_checker
  import pscs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire pscs_instr_t instr,
  input wire pscs_irq_t irq,
  input wire logic errorClear,
  input wire logic jumpValid,
  input wire pscs_addr_t jumpAddr,
  input wire logic errorFlag,
  input wire logic scanWrap,
  input wire logic programEnd,
  input wire logic [`PSCS_DEPTH_W-1:0] depth
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic isEnter = instr.valid && instr.op == PSCS_OP_ENTER;
  wire logic isDef = instr.valid && instr.op == PSCS_OP_DEFINE;
  wire logic isRet = instr.valid && instr.op == PSCS_OP_RETURN;
  wire logic isEnd = instr.valid && instr.op == PSCS_OP_END;
  sequence s_wrap;
    scanWrap && jumpValid && jumpAddr == 17'h00000;
  endsequence
  // Idle cycle before, since depth lags the stack
  a_define_wraps: assert property (isDef && depth == 5'h00 && !irq.valid && !$past(instr.valid) && !$past(irq.valid) |=> s_wrap)
    else $error("Define with empty stack did not wrap");
  a_wrap_zero: assert property (scanWrap |-> jumpAddr == 17'h00000)
    else $error("Scan wrap to nonzero address");
  a_cond_off: assert property (isEnter && !instr.cond && !irq.valid |=> !jumpValid)
    else $error("Jump on enter with condition off");
  a_error_blocks: assert property (isEnter && errorFlag && !irq.valid |=> !jumpValid)
    else $error("Enter executed while error flag set");
  a_end_pulse: assert property (isEnd |=> programEnd)
    else $error("No end pulse after end instruction");
  a_flags_kept: assert property ((isDef || isRet) && !errorClear |=> $stable(errorFlag))
    else $error("Define or return changed the error flag");
  a_depth_max: assert property (depth <= 5'h10)
    else $error("Stack depth above sixteen");
  a_idle_quiet: assert property (!instr.valid && !irq.valid |=> !jumpValid && !scanWrap)
    else $error("Jump with no instruction or interrupt");
endmodule : pscs_checker
bind pscs_sequencer pscs_checker u_chk (.clock, .rst_n, .instr, .irq,
  .errorClear, .jumpValid, .jumpAddr, .errorFlag, .scanWrap, .programEnd,
  .depth);
`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "pscs_cfg.svh"
// ============================================================
// Bench
module testbench
  import pscs_pkg::*;
;
  logic clock, rst_n, defClear, errorClear, jumpValid, errorFlag;
  logic scanWrap, programEnd, inSubroutine;
  logic [`PSCS_DEPTH_W-1:0] depth;
  logic [`PSCS_ONESHOT_W-1:0] oneShotOut;
  pscs_def_t defLoad;
  pscs_instr_t instr;
  pscs_irq_t irq;
  pscs_addr_t jumpAddr;
  pscs_id_t activeId;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  pscs_sequencer i_dut (.clock, .rst_n, .defLoad, .defClear, .instr, .irq,
    .errorClear, .jumpValid, .jumpAddr, .errorFlag, .scanWrap, .programEnd,
    .depth, .activeId, .inSubroutine, .oneShotOut);
  initial begin
    clock = 0;
    forever #20 clock = ~clock;
  end
  function automatic pscs_addr_t f(input int i);
    return pscs_addr_t'(17'h00100 + i * 16);
  endfunction : f
  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s exp %0h got %0h", n, e, s);
    end
  endtask : chk
  task automatic end_sim;
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // Jump answers land at the taking edge; status mirrors one cycle later
  task automatic op(pscs_op_t o, int id, logic c, pscs_addr_t a);
    @(posedge clock);
    instr <= '{1'b1, o, pscs_id_t'(id), c, a};
    @(posedge clock);
    instr <= '0;
    // Pulses stand only until the next edge
    #1;
  endtask : op
  task automatic intr(int id, pscs_addr_t ra);
    @(posedge clock);
    irq <= '{1'b1, pscs_id_t'(id), ra};
    @(posedge clock);
    irq <= '0;
    #1;
  endtask : intr
  task automatic jmp(logic v, pscs_addr_t a);
    chk("jumpValid", jumpValid, v);
    if (v) chk("jumpAddr", jumpAddr, a);
  endtask : jmp
  task automatic clr_err;
    @(posedge clock);
    errorClear <= 1'b1;
    @(posedge clock);
    errorClear <= 1'b0;
    @(posedge clock);
    #1;
    chk("errorFlag", errorFlag, 0);
  endtask : clr_err
  task automatic t_call;
    op(PSCS_OP_ENTER, 5, 1, 17'h00010);
    jmp(1, f(5));
    op(PSCS_OP_RETURN, 0, 0, f(5) + 1);
    jmp(1, 17'h00011);
    op(PSCS_OP_ENTER, 5, 1, 17'h00040);
    jmp(1, f(5));
    op(PSCS_OP_RETURN, 0, 0, f(5) + 1);
    jmp(1, 17'h00041);
    op(PSCS_OP_ENTER, 5, 0, 17'h00050);
    jmp(0, 0);
  endtask : t_call
  task automatic t_err;
    op(PSCS_OP_ENTER, 50, 1, 17'h00020);
    chk("errorFlag", errorFlag, 1);
    op(PSCS_OP_DEFINE, 9, 0, 17'h00023);
    chk("errorFlag", errorFlag, 1);
    op(PSCS_OP_ENTER, 5, 1, 17'h00021);
    jmp(0, 0);
    clr_err();
    op(PSCS_OP_ENTER, 100, 1, 17'h00022);
    chk("errorFlag", errorFlag, 1);
    clr_err();
    op(PSCS_OP_ENTER, 5, 1, 17'h00030);
    op(PSCS_OP_ENTER, 5, 1, f(5) + 2);
    chk("errorFlag", errorFlag, 1);
    clr_err();
    op(PSCS_OP_RETURN, 0, 0, f(5) + 3);
    jmp(1, 17'h00031);
  endtask : t_err
  task automatic t_nest;
    for (int i = 1; i <= 16; i++) begin
      op(PSCS_OP_ENTER, i, 1, f(i - 1) + 1);
      jmp(1, f(i));
    end
    op(PSCS_OP_ENTER, 17, 1, f(16) + 1);
    chk("errorFlag", errorFlag, 1);
    chk("depth", depth, 16);
    chk("activeId", activeId, 7'h10);
    chk("inSubroutine", inSubroutine, 1);
    clr_err();
    for (int i = 16; i >= 1; i--) begin
      op(PSCS_OP_RETURN, 0, 0, f(i) + 2);
      jmp(1, f(i - 1) + 2);
    end
    @(posedge clock);
    #1;
    chk("depth", depth, 0);
    chk("inSubroutine", inSubroutine, 0);
  endtask : t_nest
  task automatic t_wrap;
    op(PSCS_OP_DEFINE, 7, 0, 17'h00090);
    jmp(1, 17'h00000);
    chk("scanWrap", scanWrap, 1);
    chk("errorFlag", errorFlag, 0);
    op(PSCS_OP_END, 0, 0, 17'h00400);
    chk("programEnd", programEnd, 1);
  endtask : t_wrap
  task automatic t_irq;
    intr(3, 17'h00077);
    jmp(1, f(3));
    op(PSCS_OP_RETURN, 0, 0, f(3) + 1);
    jmp(1, 17'h00077);
    intr(40, 17'h00078);
    jmp(0, 0);
    intr(99, 17'h00088);
    jmp(1, f(99));
    op(PSCS_OP_RETURN, 0, 0, f(99) + 1);
    jmp(1, 17'h00088);
  endtask : t_irq
  task automatic t_oneshot;
    op(PSCS_OP_ONESHOT, 2, 1, 17'h00070);
    chk("oneShotOut", oneShotOut, 8'h04);
    repeat (3) @(posedge clock);
    #1;
    chk("oneShotOut", oneShotOut, 8'h04);
    op(PSCS_OP_ONESHOT, 2, 1, 17'h00070);
    chk("oneShotOut", oneShotOut, 8'h00);
  endtask : t_oneshot
  task automatic t_clear;
    @(posedge clock);
    defClear <= 1'b1;
    @(posedge clock);
    defClear <= 1'b0;
    op(PSCS_OP_ENTER, 5, 1, 17'h00060);
    jmp(0, 0);
    chk("errorFlag", errorFlag, 1);
    clr_err();
  endtask : t_clear
  // Generous ceiling; the full run needs under two hundred cycles
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    defLoad = '0;
    instr = '0;
    irq = '0;
    defClear = 1'b0;
    errorClear = 1'b0;
    rst_n = 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 22; i++) begin
      @(posedge clock);
      defLoad <= '{1'b1, pscs_id_t'(i < 21 ? i : 99), f(i < 21 ? i : 99)};
    end
    @(posedge clock);
    defLoad <= '0;
    t_call();
    t_err();
    t_nest();
    t_wrap();
    t_irq();
    t_oneshot();
    t_clear();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
